//--- rtl/fpar_pkg.sv
package fpar_pkg;
    // Restart styles
    typedef enum logic [1:0] {
        FPAR_RS_NONE,
        FPAR_RS_NOSW,
        FPAR_RS_PLAIN,
        FPAR_RS_SKIP8
    } fpar_restart_e;

    // Operating phases
    typedef enum logic [1:0] {
        FPAR_PH_STARTUP,
        FPAR_PH_CONT,
        FPAR_PH_HYS_SW,
        FPAR_PH_HYS_IDLE
    } fpar_phase_e;

    localparam int FPAR_CLK_MHZ = 200;
    // Times in microseconds
    localparam int FPAR_SUPPLY_QUAL_US = 10;
    localparam int FPAR_SEC_SUPPLY_BLANK_US = 10;
    localparam int FPAR_OPEN_LOOP_BLANK_US = 20;
    localparam int FPAR_SUPPLY_QUAL_CYC = FPAR_SUPPLY_QUAL_US * FPAR_CLK_MHZ;
    localparam int FPAR_SEC_BLANK_CYC =
        FPAR_SEC_SUPPLY_BLANK_US * FPAR_CLK_MHZ;
    localparam int FPAR_OLP_BLANK_CYC = FPAR_OPEN_LOOP_BLANK_US * FPAR_CLK_MHZ;
    // Overcurrent spike blanking in ns
    localparam int FPAR_OC_BLANK_NS = 200;
    localparam int FPAR_OC_BLANK_CYC = (FPAR_OC_BLANK_NS + 4) / 5;
    // Closed-loop timeout in microseconds
    localparam int FPAR_CL_TIMEOUT_US = 50000;
    localparam int FPAR_CL_TIMEOUT_CYC = FPAR_CL_TIMEOUT_US * FPAR_CLK_MHZ;
    localparam int FPAR_SKIP_TOGGLES = 8;
    localparam int FPAR_OC_HIT_LIMIT = 4;
    localparam int FPAR_UV_CYCLE_LIMIT = 4;
    localparam int FPAR_FAULT_N = 14;
    // Fault index positions
    localparam int FPAR_F_OTP = 0;
    localparam int FPAR_F_BROWN = 1;
    localparam int FPAR_F_LINE_OV = 2;
    localparam int FPAR_F_SEV_OC = 3;
    localparam int FPAR_F_OUT_OV = 4;
    localparam int FPAR_F_OUT_UV = 5;
    localparam int FPAR_F_CL_TMO = 6;
    localparam int FPAR_F_PRI_SUP = 7;
    localparam int FPAR_F_SENSE_SHORT = 8;
    localparam int FPAR_F_SEC_SUP = 9;
    localparam int FPAR_F_OPEN_LOOP = 10;
    localparam int FPAR_F_PRI_UV = 11;
    localparam int FPAR_F_SEC_LOCK = 12;
    localparam int FPAR_F_PEAK = 13;
endpackage

//--- rtl/fpar_qual_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fpar_qual_if;
    logic level;
    logic enable;
    logic fault;
    modport owner (output level, output enable, input fault);
    modport qual (input level, input enable, output fault);
endinterface
`default_nettype wire

//--- rtl/fpar_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fpar_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

//--- rtl/fpar_qual.sv
`timescale 1ns/1ps
`default_nettype none
// Flags a fault once the level has held for COUNT cycles while enabled
module fpar_qual #(
    parameter int COUNT = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    fpar_qual_if.qual q
);
    localparam int W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LIMIT = W'(COUNT);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    wire hit = q.level && q.enable;

    assign cnt_nxt = !hit ? '0 : (cnt_r == LIMIT) ? cnt_r : cnt_r + 1'b1;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign q.fault = hit && (cnt_r == LIMIT);
endmodule
`default_nettype wire

//--- rtl/fpar_supervisor.sv
// Summary of operation
// - Any fault stops switching; all but peak limit restart via soft-start
// - Non-switch: idle, recheck each supply-on edge
// - Plain: soft-start at supply-on, abort on fault
// - Eight-skip: wait eight supply toggles first
// - Map thermal/line faults and eight-skip faults
// - Supply/sense-short plain; peak limit resets
// - Fault checks gated by operating phase
// - Primary supply out of range holds switch off
// - Peak current turns switch off immediately
// - High line raises minimum target valley
// - Overcurrent blanking and consecutive-hit counter
// - Thermal release only below hysteresis point
// - Brown-out entry, release above brown-in
// - Non-switch reactivation requires brown-in and no overtemperature
// - Line overvoltage held while above level
// - Output overvoltage check until takeover
// - Output undervoltage cycle count until takeover
// - Sense short checked during configuration only
// - Closed-loop timeout awaits secondary handshake
// - Secondary supply out of range, eight-skip
// - Open loop beyond blanking, eight-skip
// - Secondary lockout always watched, powers down
`timescale 1ns/1ps
`default_nettype none
module fpar_supervisor
    import fpar_pkg::*;
#(
    parameter int CL_TIMEOUT_CYC = fpar_pkg::FPAR_CL_TIMEOUT_CYC,
    parameter int OC_HIT_LIMIT = fpar_pkg::FPAR_OC_HIT_LIMIT,
    parameter int UV_CYCLE_LIMIT = fpar_pkg::FPAR_UV_CYCLE_LIMIT,
    parameter int SKIP_TOGGLES = fpar_pkg::FPAR_SKIP_TOGGLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic primary_supply_on,
    input wire logic primary_supply_below_off,
    input wire logic primary_supply_over,
    input wire logic primary_supply_short,
    input wire logic temp_over_trip,
    input wire logic temp_below_hys,
    input wire logic bus_below_brown_out,
    input wire logic bus_above_brown_in,
    input wire logic bus_above_line_ov,
    input wire logic peak_current_limit,
    input wire logic severe_overcurrent_guard,
    input wire logic winding_over,
    input wire logic winding_under,
    input wire logic winding_short,
    input wire logic secondary_supply_under,
    input wire logic secondary_supply_over,
    input wire logic secondary_supply_lockout,
    input wire logic error_amplifier_over_open_loop,
    input wire logic high_line,
    input wire logic config_done,
    input wire logic soft_start_done,
    input wire logic secondary_handshake,
    input wire logic hysteretic_mode,
    input wire logic hysteretic_idle,
    input wire logic switch_cycle,
    output logic switch_enable,
    output logic soft_start_req,
    output logic secondary_power_down,
    output logic min_valley_high,
    output fpar_pkg::fpar_restart_e restart_style,
    output fpar_pkg::fpar_phase_e phase,
    output logic [fpar_pkg::FPAR_FAULT_N-1:0] fault_status,
    output logic low_power_idle
);
    import fpar_pkg::*;

    typedef enum logic [2:0] {
        FPAR_ST_WAIT_ON,
        FPAR_ST_CHECK,
        FPAR_ST_SOFT,
        FPAR_ST_RUN,
        FPAR_ST_SKIP
    } fpar_state_e;

    localparam int NIN = 22;
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] s;
    assign raw_in = {primary_supply_on, primary_supply_below_off,
        primary_supply_over, primary_supply_short, temp_over_trip,
        temp_below_hys, bus_below_brown_out, bus_above_brown_in,
        bus_above_line_ov, peak_current_limit, severe_overcurrent_guard,
        winding_over, winding_under, winding_short, secondary_supply_under,
        secondary_supply_over, secondary_supply_lockout,
        error_amplifier_over_open_loop, high_line, secondary_handshake,
        switch_cycle, winding_short};

    fpar_sync #(.WIDTH(NIN)) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .async_in(raw_in),
        .sync_out(s)
    );

    wire s_sup_on = s[21];
    wire s_below_off = s[20];
    wire s_sup_over = s[19];
    wire s_otp_trip = s[17];
    wire s_otp_hys = s[16];
    wire s_bo = s[15];
    wire s_bi = s[14];
    wire s_lov = s[13];
    wire s_peak = s[12];
    wire s_oc = s[11];
    wire s_w_over = s[10];
    wire s_w_under = s[9];
    wire s_w_short = s[8];
    wire s_sec_uv = s[7];
    wire s_sec_ov = s[6];
    wire s_sec_lock = s[5];
    wire s_olp = s[4];
    wire s_hline = s[3];
    wire s_hshake = s[2];
    wire s_cycle = s[1];

    fpar_state_e st_r;
    fpar_state_e st_nxt;
    fpar_restart_e style_r;
    logic otp_r;
    logic brown_r;
    logic takeover_r;
    logic sup_on_d_r;
    logic [3:0] skip_cnt_r;
    logic [$clog2(OC_HIT_LIMIT+1)-1:0] oc_cnt_r;
    logic [$clog2(UV_CYCLE_LIMIT+1)-1:0] uv_cnt_r;
    logic [$clog2(CL_TIMEOUT_CYC+1)-1:0] tmo_r;
    logic [FPAR_FAULT_N-1:0] flt;

    // Phase from state, takeover and idle input
    wire startup_ph = (st_r == FPAR_ST_SOFT) || !takeover_r;
    wire idle_ph = hysteretic_idle;
    wire active = (st_r == FPAR_ST_SOFT) || (st_r == FPAR_ST_RUN);
    wire after_start = active && !startup_ph && !idle_ph;
    wire sup_rise = s_sup_on && !sup_on_d_r;

    fpar_qual_if q_pri_lo ();
    fpar_qual_if q_pri_hi ();
    fpar_qual_if q_sec_uv ();
    fpar_qual_if q_sec_ov ();
    fpar_qual_if q_olp ();
    fpar_qual_if q_ocb ();

    assign q_pri_lo.level = s_below_off;
    assign q_pri_lo.enable = active;
    assign q_pri_hi.level = s_sup_over;
    assign q_pri_hi.enable = active && !idle_ph;
    assign q_sec_uv.level = s_sec_uv;
    assign q_sec_uv.enable = after_start;
    assign q_sec_ov.level = s_sec_ov;
    assign q_sec_ov.enable = after_start;
    assign q_olp.level = s_olp;
    assign q_olp.enable = after_start && !hysteretic_mode;
    assign q_ocb.level = s_oc;
    assign q_ocb.enable = active && !idle_ph;

    fpar_qual #(.COUNT(FPAR_SUPPLY_QUAL_CYC)) u_q_pri_lo (
        .clk(clk), .arst_n(arst_n), .q(q_pri_lo));
    fpar_qual #(.COUNT(FPAR_SUPPLY_QUAL_CYC)) u_q_pri_hi (
        .clk(clk), .arst_n(arst_n), .q(q_pri_hi));
    fpar_qual #(.COUNT(FPAR_SEC_BLANK_CYC)) u_q_sec_uv (
        .clk(clk), .arst_n(arst_n), .q(q_sec_uv));
    fpar_qual #(.COUNT(FPAR_SEC_BLANK_CYC)) u_q_sec_ov (
        .clk(clk), .arst_n(arst_n), .q(q_sec_ov));
    fpar_qual #(.COUNT(FPAR_OLP_BLANK_CYC)) u_q_olp (
        .clk(clk), .arst_n(arst_n), .q(q_olp));
    fpar_qual #(.COUNT(FPAR_OC_BLANK_CYC)) u_q_ocb (
        .clk(clk), .arst_n(arst_n), .q(q_ocb));

    wire tmo_hit = (tmo_r == ($bits(tmo_r))'(CL_TIMEOUT_CYC));
    wire startup_chk = active && startup_ph && !idle_ph;

    assign flt[FPAR_F_OTP] = otp_r;
    assign flt[FPAR_F_BROWN] = brown_r;
    assign flt[FPAR_F_LINE_OV] = s_lov && !idle_ph;
    assign flt[FPAR_F_SEV_OC] =
        (oc_cnt_r == ($bits(oc_cnt_r))'(OC_HIT_LIMIT));
    assign flt[FPAR_F_OUT_OV] = active && !takeover_r && s_w_over;
    assign flt[FPAR_F_OUT_UV] =
        (uv_cnt_r == ($bits(uv_cnt_r))'(UV_CYCLE_LIMIT));
    assign flt[FPAR_F_CL_TMO] = startup_chk && tmo_hit;
    assign flt[FPAR_F_PRI_SUP] = q_pri_hi.fault;
    assign flt[FPAR_F_SENSE_SHORT] =
        !config_done && s_w_short && sup_on_d_r;
    assign flt[FPAR_F_SEC_SUP] = q_sec_uv.fault || q_sec_ov.fault;
    assign flt[FPAR_F_OPEN_LOOP] = q_olp.fault;
    assign flt[FPAR_F_PRI_UV] = q_pri_lo.fault;
    assign flt[FPAR_F_SEC_LOCK] = s_sec_lock;
    assign flt[FPAR_F_PEAK] = s_peak;

    // Restart style per fault group; short of primary supply records none
    wire grp_nosw = otp_r || brown_r || flt[FPAR_F_LINE_OV];
    wire grp_skip = flt[FPAR_F_SEV_OC] || flt[FPAR_F_OUT_OV] ||
        flt[FPAR_F_OUT_UV] || flt[FPAR_F_CL_TMO] ||
        flt[FPAR_F_SEC_SUP] || flt[FPAR_F_OPEN_LOOP];
    wire grp_plain = flt[FPAR_F_PRI_SUP] || flt[FPAR_F_PRI_UV] ||
        flt[FPAR_F_SENSE_SHORT];
    wire any_fault = grp_nosw || grp_skip || grp_plain;
    fpar_restart_e style_sel;
    assign style_sel = grp_nosw ? FPAR_RS_NOSW :
        grp_skip ? FPAR_RS_SKIP8 : FPAR_RS_PLAIN;
    wire act_ok = s_bi && !otp_r && !brown_r && !s_lov;

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            FPAR_ST_WAIT_ON: if (sup_rise) begin
                if (style_r == FPAR_RS_PLAIN || style_r == FPAR_RS_NONE) begin
                    st_nxt = FPAR_ST_SOFT;
                end else begin
                    st_nxt = FPAR_ST_CHECK;
                end
            end
            FPAR_ST_CHECK: st_nxt = act_ok && !any_fault ?
                FPAR_ST_SOFT : FPAR_ST_WAIT_ON;
            FPAR_ST_SOFT: if (any_fault) begin
                st_nxt = (style_sel == FPAR_RS_SKIP8) ?
                    FPAR_ST_SKIP : FPAR_ST_WAIT_ON;
            end else if (soft_start_done) begin
                st_nxt = FPAR_ST_RUN;
            end
            FPAR_ST_RUN: if (any_fault) begin
                st_nxt = (style_sel == FPAR_RS_SKIP8) ?
                    FPAR_ST_SKIP : FPAR_ST_WAIT_ON;
            end
            FPAR_ST_SKIP: if (sup_rise &&
                skip_cnt_r == 4'(SKIP_TOGGLES - 1)) begin
                st_nxt = FPAR_ST_SOFT;
            end
        endcase
        if (flt[FPAR_F_SEC_LOCK] || primary_supply_short) begin
            st_nxt = FPAR_ST_WAIT_ON;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= FPAR_ST_WAIT_ON;
            style_r <= FPAR_RS_NONE;
            sup_on_d_r <= 1'b0;
            skip_cnt_r <= '0;
        end else begin
            st_r <= st_nxt;
            sup_on_d_r <= s_sup_on;
            if (active && any_fault) begin
                style_r <= style_sel;
            end
            skip_cnt_r <= (st_r != FPAR_ST_SKIP) ? '0 :
                sup_rise ? skip_cnt_r + 4'h1 : skip_cnt_r;
        end
    end

    // Thermal and brown-out hysteresis latches
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            otp_r <= 1'b0;
            brown_r <= 1'b0;
        end else begin
            otp_r <= (s_otp_trip && !idle_ph) ||
                (otp_r && !s_otp_hys);
            brown_r <= (s_bo && !idle_ph) || (brown_r && !s_bi);
        end
    end

    // Takeover, timeout and consecutive counters
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            takeover_r <= 1'b0;
            tmo_r <= '0;
            oc_cnt_r <= '0;
            uv_cnt_r <= '0;
        end else if (!active) begin
            takeover_r <= 1'b0;
            tmo_r <= '0;
            oc_cnt_r <= '0;
            uv_cnt_r <= '0;
        end else begin
            takeover_r <= takeover_r || s_hshake;
            if (!takeover_r && !tmo_hit) begin
                tmo_r <= tmo_r + 1'b1;
            end
            if (s_cycle && !flt[FPAR_F_SEV_OC]) begin
                oc_cnt_r <= q_ocb.fault ? oc_cnt_r + 1'b1 : '0;
            end
            if (s_cycle && soft_start_done && !takeover_r &&
                !flt[FPAR_F_OUT_UV]) begin
                uv_cnt_r <= s_w_under ? uv_cnt_r + 1'b1 : '0;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            switch_enable <= 1'b0;
            soft_start_req <= 1'b0;
            secondary_power_down <= 1'b0;
            min_valley_high <= 1'b0;
            restart_style <= FPAR_RS_NONE;
            phase <= FPAR_PH_STARTUP;
            fault_status <= '0;
            low_power_idle <= 1'b0;
        end else begin
            switch_enable <= (st_nxt == FPAR_ST_SOFT ||
                st_nxt == FPAR_ST_RUN) && !any_fault && !s_peak;
            soft_start_req <= (st_nxt == FPAR_ST_SOFT);
            secondary_power_down <= s_sec_lock;
            min_valley_high <= s_hline;
            restart_style <= style_r;
            phase <= idle_ph ? FPAR_PH_HYS_IDLE :
                hysteretic_mode ? FPAR_PH_HYS_SW :
                startup_ph ? FPAR_PH_STARTUP : FPAR_PH_CONT;
            fault_status <= flt;
            low_power_idle <= (st_nxt == FPAR_ST_WAIT_ON) ||
                (st_nxt == FPAR_ST_SKIP);
        end
    end
endmodule
`default_nettype wire

//--- test/fpar_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fpar_properties
    import fpar_pkg::*;
#(
    parameter int CL_TIMEOUT_CYC = 100
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic primary_supply_below_off,
    input wire logic temp_over_trip,
    input wire logic bus_above_line_ov,
    input wire logic secondary_supply_lockout,
    input wire logic secondary_handshake,
    input wire logic switch_enable,
    input wire logic soft_start_req,
    input wire logic secondary_power_down,
    input var fpar_pkg::fpar_restart_e restart_style,
    input wire logic [fpar_pkg::FPAR_FAULT_N-1:0] fault_status
);
    logic [31:0] low_cnt_r;
    logic [31:0] cl_cnt_r;
    logic hs_seen_r;
    logic cl_run;
    assign cl_run = switch_enable && !hs_seen_r;
    // Time the supply stays low, and switching time without takeover
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_cnt_r <= 32'h0;
            cl_cnt_r <= 32'h0;
            hs_seen_r <= 1'b0;
        end else begin
            low_cnt_r <= primary_supply_below_off ? low_cnt_r + 32'h1 : 32'h0;
            hs_seen_r <= switch_enable && (hs_seen_r || secondary_handshake);
            cl_cnt_r <= cl_run ? cl_cnt_r + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_soft_start_first: assert property (
        $rose(switch_enable) && !$past(fault_status[FPAR_F_PEAK])
        |-> soft_start_req)
        else $error("switching began without soft-start");
    a_thermal_stop: assert property (
        (temp_over_trip [*2] ##0 switch_enable) |-> ##[0:6] !switch_enable)
        else $error("over-temperature left switching on");
    a_nosw_style: assert property (
        $rose(fault_status[FPAR_F_OTP] | fault_status[FPAR_F_BROWN] |
        fault_status[FPAR_F_LINE_OV]) |-> ##[0:3] restart_style == FPAR_RS_NOSW)
        else $error("thermal or line fault without non-switch restart");
    a_skip_style: assert property (
        $rose(fault_status[FPAR_F_SEV_OC] | fault_status[FPAR_F_CL_TMO])
        |-> ##[0:3] restart_style == FPAR_RS_SKIP8)
        else $error("overcurrent or timeout without eight-skip restart");
    a_plain_style: assert property (
        $rose(fault_status[FPAR_F_SENSE_SHORT] | fault_status[FPAR_F_PRI_SUP])
        |-> ##[0:3] restart_style == FPAR_RS_PLAIN)
        else $error("supply or sense short without plain restart");
    a_line_ov_held: assert property (
        bus_above_line_ov [*8] |-> !switch_enable)
        else $error("switching during line overvoltage");
    a_supply_low_off: assert property (
        low_cnt_r > 32'(FPAR_SUPPLY_QUAL_CYC + 16) |-> !switch_enable)
        else $error("switching with primary supply held low");
    a_cl_bound: assert property (
        cl_cnt_r <= 32'(CL_TIMEOUT_CYC + 16))
        else $error("switching past the closed-loop timeout");
    a_lockout_down: assert property (
        secondary_supply_lockout [*3] |-> ##[0:4] secondary_power_down)
        else $error("secondary lockout without power-down");
endmodule
bind fpar_supervisor fpar_properties #(.CL_TIMEOUT_CYC(CL_TIMEOUT_CYC)) u_props (
    .clk(clk), .arst_n(arst_n),
    .primary_supply_below_off(primary_supply_below_off),
    .temp_over_trip(temp_over_trip), .bus_above_line_ov(bus_above_line_ov),
    .secondary_supply_lockout(secondary_supply_lockout),
    .secondary_handshake(secondary_handshake),
    .switch_enable(switch_enable), .soft_start_req(soft_start_req),
    .secondary_power_down(secondary_power_down),
    .restart_style(restart_style), .fault_status(fault_status));
`default_nettype wire

//--- test/fpar_sec_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpar_sec_model #(
    parameter int HS_DELAY = 20
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic switch_enable,
    input wire logic power_down,
    input wire logic hs_en,
    input wire logic uv_cmd,
    input wire logic ov_cmd,
    input wire logic lock_cmd,
    output logic handshake,
    output logic supply_under,
    output logic supply_over,
    output logic lockout
);
    logic [7:0] run_cnt_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run_cnt_r <= 8'h0;
        end else if (!switch_enable || power_down) begin
            run_cnt_r <= 8'h0;
        end else if (run_cnt_r != 8'hff) begin
            run_cnt_r <= run_cnt_r + 8'h1;
        end
    end
    // Takeover only after the primary has switched for a while
    assign handshake = hs_en && run_cnt_r >= 8'(HS_DELAY);
    // A powered-down secondary reports no supply faults
    assign supply_under = uv_cmd && !power_down;
    assign supply_over = ov_cmd && !power_down;
    assign lockout = lock_cmd;
endmodule
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
    fail_count++; $display("Error t=%0t got %h exp %h", $time, got, exp); \
    end end
module testbench;
    import fpar_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic sup_on = 1'b0;
    logic [10:0] flt = 11'h0;
    logic hs_en = 1'b0;
    logic lock_cmd = 1'b0;
    logic high_line = 1'b0;
    logic config_done = 1'b0;
    logic soft_done = 1'b0;
    logic wind_short = 1'b0;
    logic sw_cycle = 1'b0;
    logic peak = 1'b0;
    logic hys_mode = 1'b0;
    logic hys_idle = 1'b0;
    logic hs, sec_uv, sec_ov, sec_lock;
    logic sw_en, ss_req, pdown, mv_high, lp_idle;
    fpar_restart_e style;
    fpar_phase_e phase;
    logic [FPAR_FAULT_N-1:0] fstat;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    always #2.5 clk = ~clk;
    fpar_supervisor #(.CL_TIMEOUT_CYC(400)) u_dut (
        .clk(clk), .arst_n(arst_n), .primary_supply_on(sup_on),
        .primary_supply_below_off(flt[3]), .primary_supply_over(flt[4]),
        .primary_supply_short(1'b0), .temp_over_trip(flt[0]),
        .temp_below_hys(!flt[0]), .bus_below_brown_out(flt[2]),
        .bus_above_brown_in(!flt[2]), .bus_above_line_ov(flt[1]),
        .peak_current_limit(peak), .severe_overcurrent_guard(flt[8]),
        .winding_over(flt[9]), .winding_under(flt[10]),
        .winding_short(wind_short), .secondary_supply_under(sec_uv),
        .secondary_supply_over(sec_ov), .secondary_supply_lockout(sec_lock),
        .error_amplifier_over_open_loop(flt[7]), .high_line(high_line),
        .config_done(config_done), .soft_start_done(soft_done),
        .secondary_handshake(hs), .hysteretic_mode(hys_mode),
        .hysteretic_idle(hys_idle), .switch_cycle(sw_cycle),
        .switch_enable(sw_en), .soft_start_req(ss_req),
        .secondary_power_down(pdown), .min_valley_high(mv_high),
        .restart_style(style), .phase(phase), .fault_status(fstat),
        .low_power_idle(lp_idle));
    fpar_sec_model u_sec (
        .clk(clk), .arst_n(arst_n), .switch_enable(sw_en),
        .power_down(pdown), .hs_en(hs_en), .uv_cmd(flt[5]),
        .ov_cmd(flt[6]), .lock_cmd(lock_cmd), .handshake(hs),
        .supply_under(sec_uv), .supply_over(sec_ov), .lockout(sec_lock));
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Switching-cycle pulse every 16 clocks; hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        sw_cycle <= sw_en && cyc[3:0] == 4'h0;
        if (cyc == 60000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic pulse();
        @(posedge clk);
        sup_on <= 1'b0;
        repeat (10) @(posedge clk);
        sup_on <= 1'b1;
    endtask
    task automatic recover(int n_exp);
        int k;
        int n;
        for (k = 1; k <= 10; k++) begin
            pulse();
            for (n = 0; n < 30 && sw_en !== 1'b1; n++)
                @(negedge clk);
            if (sw_en === 1'b1)
                break;
        end
        `CHK(k, n_exp)
        `CHK(ss_req, 1'b1)
    endtask
    // Without takeover the phase stays in startup
    task automatic bring_up();
        int n;
        fpar_phase_e ph_exp;
        ph_exp = hs_en ? FPAR_PH_CONT : FPAR_PH_STARTUP;
        @(posedge clk);
        soft_done <= 1'b1;
        for (n = 0; n < 60 && phase !== ph_exp; n++)
            @(negedge clk);
        `CHK(phase, ph_exp)
        repeat (40) @(posedge clk);
    endtask
    task automatic sense_short_case();
        int n;
        @(posedge clk);
        wind_short <= 1'b1;
        sup_on <= 1'b1;
        for (n = 0; n < 40 && fstat[FPAR_F_SENSE_SHORT] !== 1'b1; n++)
            @(negedge clk);
        `CHK(fstat[FPAR_F_SENSE_SHORT], 1'b1)
        repeat (6) @(negedge clk);
        `CHK(style, FPAR_RS_PLAIN)
        `CHK(sw_en, 1'b0)
        @(posedge clk);
        wind_short <= 1'b0;
        config_done <= 1'b1;
        recover(1);
    endtask
    task automatic fault_case(int idx, int fb, fpar_restart_e sty,
            logic hs_next);
        int n;
        logic [FPAR_FAULT_N-1:0] seen;
        seen = '0;
        bring_up();
        @(posedge clk);
        if (idx < 11)
            flt[idx] <= 1'b1;
        // Most status bits stand only while the state is still active
        for (n = 0; n < 4200 && sw_en !== 1'b0; n++) begin
            @(negedge clk);
            seen = seen | fstat;
        end
        repeat (4) begin
            @(negedge clk);
            seen = seen | fstat;
        end
        `CHK(sw_en, 1'b0)
        `CHK(seen[fb], 1'b1)
        `CHK(style, sty)
        if (sty == FPAR_RS_NOSW) begin
            `CHK(lp_idle, 1'b1)
            pulse();
            repeat (30) @(negedge clk);
            `CHK(sw_en, 1'b0)
        end
        @(posedge clk);
        flt <= 11'h0;
        hs_en <= hs_next;
        soft_done <= 1'b0;
        recover(sty == FPAR_RS_SKIP8 ? 8 : 1);
    endtask
    task automatic level_case();
        @(posedge clk);
        high_line <= 1'b1;
        lock_cmd <= 1'b1;
        repeat (10) @(negedge clk);
        `CHK(mv_high, 1'b1)
        `CHK(pdown, 1'b1)
        @(posedge clk);
        high_line <= 1'b0;
        repeat (10) @(negedge clk);
        `CHK(mv_high, 1'b0)
    endtask
    task automatic peak_case();
        @(posedge clk);
        peak <= 1'b1;
        repeat (5) @(negedge clk);
        `CHK(sw_en, 1'b0)
        `CHK(fstat[FPAR_F_PEAK], 1'b1)
        @(posedge clk);
        peak <= 1'b0;
        repeat (5) @(negedge clk);
        `CHK(sw_en, 1'b1)
    endtask
    // Line overvoltage must be ignored while idle in hysteretic mode
    task automatic hys_case();
        @(posedge clk);
        hys_mode <= 1'b1;
        repeat (3) @(negedge clk);
        `CHK(phase, FPAR_PH_HYS_SW)
        @(posedge clk);
        hys_idle <= 1'b1;
        flt[1] <= 1'b1;
        repeat (6) @(negedge clk);
        `CHK(phase, FPAR_PH_HYS_IDLE)
        `CHK(fstat[FPAR_F_LINE_OV], 1'b0)
        `CHK(sw_en, 1'b1)
        @(posedge clk);
        flt[1] <= 1'b0;
        repeat (4) @(posedge clk);
        hys_idle <= 1'b0;
        hys_mode <= 1'b0;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        sense_short_case();
        fault_case(9, FPAR_F_OUT_OV, FPAR_RS_SKIP8, 1'b0);
        fault_case(10, FPAR_F_OUT_UV, FPAR_RS_SKIP8, 1'b0);
        fault_case(11, FPAR_F_CL_TMO, FPAR_RS_SKIP8, 1'b1);
        fault_case(0, FPAR_F_OTP, FPAR_RS_NOSW, 1'b1);
        fault_case(2, FPAR_F_BROWN, FPAR_RS_NOSW, 1'b1);
        fault_case(1, FPAR_F_LINE_OV, FPAR_RS_NOSW, 1'b1);
        fault_case(8, FPAR_F_SEV_OC, FPAR_RS_SKIP8, 1'b1);
        fault_case(3, FPAR_F_PRI_UV, FPAR_RS_PLAIN, 1'b1);
        fault_case(4, FPAR_F_PRI_SUP, FPAR_RS_PLAIN, 1'b1);
        fault_case(5, FPAR_F_SEC_SUP, FPAR_RS_SKIP8, 1'b1);
        fault_case(6, FPAR_F_SEC_SUP, FPAR_RS_SKIP8, 1'b1);
        fault_case(7, FPAR_F_OPEN_LOOP, FPAR_RS_SKIP8, 1'b1);
        bring_up();
        peak_case();
        hys_case();
        level_case();
        close_out();
    end
endmodule
`default_nettype wire
